// >>> core/cts_core.sv
// cts_core: trigger conditioning, burst sequencing and strobe output of a machine-vision camera.
// assumes inputs synchronous to clock; frame_done pulses when readout of a frame is complete.
//
// Contract
// - Burst frame count accepted only between 1 and 1023.
// - Count one means single-frame trigger mode, above one multi-frame.
// - Each accepted trigger gives exactly n exposures and n frames, then stops.
// - Programmable microsecond delay between trigger receipt and trigger becoming active.
// - With cache on, triggers arriving while busy are stored, at most three.
// - With cache off, triggers arriving while busy are discarded.
// - Cached trigger's first exposure waits for previous trigger's last frame.
// - Activation on rising, falling or either edge starts acquisition.
// - Level high or low keeps acquiring while the input holds that level.
// - Line debounce time programmable from 0 to 1000000 microseconds.
// - Trigger pulses shorter than the debounce time are ignored.
// - Opto output always driven; bidirectional line driven only in strobe mode.
// - Per-line inversion of the output level, off after reset.
// - With strobe enabled, the output asserts on the selected source event.
// - Thirteen source events: exposure, acquisition, burst, frame, triggers, wait state.
// - Timer source: software line trigger gives delayed pulse of strobe duration.
// - Strobe duration zero means pulse width equals exposure time.
// - Strobe delay after the event, programmable from 0 to 10000 microseconds.
// - Strobe pre-delay asserts the strobe before exposure begins.
// - External triggers honoured only with trigger mode on; otherwise free run.
`timescale 1ns/1ps
`default_nettype none
module cts_core (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // trigger, acquisition and readout inputs
  input wire logic line0_in,
  input wire logic sw_trig,
  input wire logic cnt_trig,
  input wire logic line_trig_sw,
  input wire logic acq_en,
  input wire logic frame_done,
  // bidirectional line
  input wire logic line2_in,
  output logic line2_out_reg,
  output logic line2_oe_reg,
  // configuration
  input wire cts_pkg::cts_trig_cfg_t trig_cfg,
  input wire cts_pkg::cts_strb_cfg_t strb_cfg,
  input wire logic [cts_pkg::US_W-1:0] exposure_us,
  input wire logic burst_wr,
  input wire logic [9:0] burst_val,
  // outputs and status
  output logic line1_out_reg,
  output logic [9:0] burst_reg,
  output logic multi_frame_reg,
  output logic exposing_reg,
  output logic trig_wait_reg,
  output logic [1:0] pend_reg
);
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_PRE, ST_EXPOSE, ST_READ} cts_state_t;
  localparam logic [6:0] US_LAST = 7'(cts_pkg::US_CYCLES - 1);

  cts_state_t st_reg;
  logic [6:0] us_cnt_reg;
  logic us_tick_reg;
  logic [19:0] deb_us;
  logic hw_raw, hw_lvl, hw_prev_reg, acq_prev_reg;
  logic edge_hit, level_mode, level_act, trig_ev;
  logic [9:0] frame_cnt_reg;
  logic last_frame, burst_last_done, pend_push, pend_pop;
  logic dly_go_reg, pre_go_reg, exp_go_reg;
  logic dly_done, pre_done, exp_done;
  logic [15:0] ev; // one bit per source code, spare codes stay low
  logic sel_ev, s_busy_reg, sdly_go_reg, sdur_go_reg, strobe_reg;
  logic sdly_done, sdur_done;
  logic [13:0] sdly_us;
  logic [cts_pkg::US_W-1:0] sdur_us;

  ////////////////////////////////////////////////////////////////////////////
  // microsecond tick shared by every timer
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      us_cnt_reg <= '0;
      us_tick_reg <= 1'b0;
    end
    else
    begin
      us_tick_reg <= (us_cnt_reg == US_LAST);
      us_cnt_reg <= (us_cnt_reg == US_LAST) ? 7'h00 : us_cnt_reg + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger conditioning
  // settings above the top of the range saturate rather than wrap
  assign deb_us = (trig_cfg.debounce_us > cts_pkg::DEBOUNCE_MAX_US) ?
                  cts_pkg::DEBOUNCE_MAX_US : trig_cfg.debounce_us;
  // line 2 serves as trigger input only while it is not driving a strobe
  assign hw_raw = (trig_cfg.hw_line2 && !strb_cfg.line2_strobe) ? line2_in : line0_in;

  cts_debounce u_deb (.clock(clock), .rstn(rstn), .us_tick(us_tick_reg), .din(hw_raw), .deb_us(deb_us),
    .dout_reg(hw_lvl));

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      hw_prev_reg <= 1'b0;
      acq_prev_reg <= 1'b0;
    end
    else
    begin
      hw_prev_reg <= hw_lvl;
      acq_prev_reg <= acq_en;
    end
  end

  always_comb
  begin
    case (trig_cfg.act)
      cts_pkg::ACT_RISE: edge_hit = hw_lvl && !hw_prev_reg;
      cts_pkg::ACT_FALL: edge_hit = !hw_lvl && hw_prev_reg;
      cts_pkg::ACT_ANY: edge_hit = hw_lvl != hw_prev_reg;
      default: edge_hit = 1'b0;
    endcase
  end

  assign level_mode = (trig_cfg.act == cts_pkg::ACT_HIGH) || (trig_cfg.act == cts_pkg::ACT_LOW);
  assign level_act = (trig_cfg.act == cts_pkg::ACT_HIGH) ? hw_lvl : !hw_lvl;
  assign trig_ev = trig_cfg.mode_on && acq_en && (edge_hit || sw_trig || cnt_trig);

  ////////////////////////////////////////////////////////////////////////////
  // burst count and trigger cache
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      burst_reg <= cts_pkg::BURST_RST;
      multi_frame_reg <= 1'b0;
    end
    else
    begin
      if (burst_wr && burst_val >= cts_pkg::BURST_MIN && burst_val <= cts_pkg::BURST_MAX)
        burst_reg <= burst_val;
      multi_frame_reg <= burst_reg > cts_pkg::BURST_MIN;
    end
  end

  assign last_frame = frame_cnt_reg >= burst_reg - 10'h001;
  assign burst_last_done = (st_reg == ST_READ) && frame_done && last_frame;
  // a trigger while busy is cached only below the limit, otherwise dropped
  assign pend_push = trig_ev && (st_reg != ST_IDLE) && trig_cfg.cache_en && (pend_reg < cts_pkg::CACHE_MAX);
  assign pend_pop = acq_en && trig_cfg.mode_on && !level_mode && (pend_reg != 2'h0) &&
                    ((st_reg == ST_IDLE && !trig_ev) || burst_last_done);

  always_ff @(posedge clock)
  begin
    if (!rstn)
      pend_reg <= 2'h0;
    else if (!trig_cfg.cache_en || !acq_en)
      pend_reg <= 2'h0;
    else
      pend_reg <= pend_reg + {1'b0, pend_push} - {1'b0, pend_pop};
  end

  ////////////////////////////////////////////////////////////////////////////
  // acquisition sequence: delay, pre-delay, exposure, readout
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      st_reg <= ST_IDLE;
      frame_cnt_reg <= 10'h000;
      dly_go_reg <= 1'b0;
      pre_go_reg <= 1'b0;
      exp_go_reg <= 1'b0;
    end
    else
    begin
      dly_go_reg <= 1'b0;
      pre_go_reg <= 1'b0;
      exp_go_reg <= 1'b0;
      case (st_reg)
        ST_IDLE:
        begin
          frame_cnt_reg <= 10'h000;
          if (acq_en && (!trig_cfg.mode_on || (level_mode && level_act)))
          begin
            pre_go_reg <= 1'b1;
            st_reg <= ST_PRE;
          end
          else if (!level_mode && (trig_ev || pend_pop))
          begin
            dly_go_reg <= 1'b1;
            st_reg <= ST_DELAY;
          end
        end
        ST_DELAY:
          if (dly_done)
          begin
            pre_go_reg <= 1'b1;
            st_reg <= ST_PRE;
          end
        ST_PRE:
          if (pre_done)
          begin
            exp_go_reg <= 1'b1;
            st_reg <= ST_EXPOSE;
          end
        ST_EXPOSE:
          if (exp_done)
            st_reg <= ST_READ;
        ST_READ:
          if (frame_done && !last_frame)
          begin
            frame_cnt_reg <= frame_cnt_reg + 10'h001;
            pre_go_reg <= 1'b1;
            st_reg <= ST_PRE;
          end
          else if (frame_done)
          begin
            frame_cnt_reg <= 10'h000;
            // next burst only after this burst's last frame is out
            if (acq_en && (!trig_cfg.mode_on || (level_mode && level_act)))
            begin
              pre_go_reg <= 1'b1;
              st_reg <= ST_PRE;
            end
            else if (pend_pop)
            begin
              dly_go_reg <= 1'b1;
              st_reg <= ST_DELAY;
            end
            else
              st_reg <= ST_IDLE;
          end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  cts_us_timer u_dly (.clock(clock), .rstn(rstn), .us_tick(us_tick_reg), .start(dly_go_reg),
    .count_us(trig_cfg.delay_us), .busy_reg(), .done_reg(dly_done));
  cts_us_timer u_pre (.clock(clock), .rstn(rstn), .us_tick(us_tick_reg), .start(pre_go_reg),
    .count_us(strb_cfg.pre_delay_us), .busy_reg(), .done_reg(pre_done));
  cts_us_timer u_exp (.clock(clock), .rstn(rstn), .us_tick(us_tick_reg), .start(exp_go_reg),
    .count_us(exposure_us), .busy_reg(), .done_reg(exp_done));

  ////////////////////////////////////////////////////////////////////////////
  // line source events
  always_comb
  begin
    ev = '0;
    // with a pre-delay the exposure-start event fires at its beginning
    ev[cts_pkg::SRC_EXP_START] = (strb_cfg.pre_delay_us != '0) ? pre_go_reg : exp_go_reg;
    ev[cts_pkg::SRC_EXP_END] = (st_reg == ST_EXPOSE) && exp_done;
    ev[cts_pkg::SRC_ACQ_START] = acq_en && !acq_prev_reg;
    ev[cts_pkg::SRC_ACQ_STOP] = !acq_en && acq_prev_reg;
    ev[cts_pkg::SRC_BURST_START] = pre_go_reg && (frame_cnt_reg == 10'h000) && (st_reg != ST_READ);
    ev[cts_pkg::SRC_BURST_END] = burst_last_done;
    ev[cts_pkg::SRC_FRAME_WAIT] = trig_wait_reg;
    ev[cts_pkg::SRC_FRAME_START] = exp_go_reg;
    ev[cts_pkg::SRC_FRAME_END] = (st_reg == ST_READ) && frame_done;
    ev[cts_pkg::SRC_SOFT] = sw_trig;
    ev[cts_pkg::SRC_HARD] = edge_hit;
    ev[cts_pkg::SRC_COUNTER] = cnt_trig;
    ev[cts_pkg::SRC_TIMER] = line_trig_sw;
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobe: delay, then pulse; events during a strobe are not queued
  assign sel_ev = strb_cfg.strobe_en && ev[strb_cfg.src];
  assign sdly_us = (strb_cfg.delay_us > cts_pkg::STROBE_DELAY_MAX_US) ?
                   cts_pkg::STROBE_DELAY_MAX_US : strb_cfg.delay_us;
  assign sdur_us = (strb_cfg.duration_us == '0) ? exposure_us : strb_cfg.duration_us;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      s_busy_reg <= 1'b0;
      sdly_go_reg <= 1'b0;
      sdur_go_reg <= 1'b0;
      strobe_reg <= 1'b0;
    end
    else
    begin
      sdly_go_reg <= 1'b0;
      sdur_go_reg <= 1'b0;
      if (!s_busy_reg && sel_ev)
      begin
        s_busy_reg <= 1'b1;
        sdly_go_reg <= 1'b1;
      end
      if (sdly_done)
      begin
        strobe_reg <= 1'b1;
        sdur_go_reg <= 1'b1;
      end
      if (sdur_done)
      begin
        strobe_reg <= 1'b0;
        s_busy_reg <= 1'b0;
      end
    end
  end

  cts_us_timer #(.W(14)) u_sdly (.clock(clock), .rstn(rstn), .us_tick(us_tick_reg), .start(sdly_go_reg),
    .count_us(sdly_us), .busy_reg(), .done_reg(sdly_done));
  cts_us_timer u_sdur (.clock(clock), .rstn(rstn), .us_tick(us_tick_reg), .start(sdur_go_reg),
    .count_us(sdur_us), .busy_reg(), .done_reg(sdur_done));

  ////////////////////////////////////////////////////////////////////////////
  // output lines and status
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      line1_out_reg <= cts_pkg::LINE_RST;
      line2_out_reg <= cts_pkg::LINE_RST;
      line2_oe_reg <= 1'b0;
      exposing_reg <= 1'b0;
      trig_wait_reg <= 1'b0;
    end
    else
    begin
      line1_out_reg <= strobe_reg ^ strb_cfg.invert1;
      line2_out_reg <= strobe_reg ^ strb_cfg.invert2;
      line2_oe_reg <= strb_cfg.line2_strobe;
      exposing_reg <= st_reg == ST_EXPOSE;
      trig_wait_reg <= (st_reg == ST_IDLE) && acq_en && trig_cfg.mode_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_last_out;
    burst_last_done && !pend_pop && trig_cfg.mode_on && !level_mode;
  endsequence

  burst_range_a: assert property (burst_reg >= 10'h001) else $error("burst count out of range");
  multi_mode_a: assert property (multi_frame_reg == ($past(burst_reg) > 10'h001)) else $error("mode flag wrong");
  burst_stop_a: assert property (s_last_out |=> st_reg == ST_IDLE) else $error("burst did not stop");
  frame_bound_a: assert property (st_reg != ST_IDLE |-> frame_cnt_reg < burst_reg) else $error("too many frames");
  cache_limit_a: assert property (pend_reg == 2'h3 && !pend_pop && acq_en
    && trig_cfg.cache_en |=> pend_reg == 2'h3) else $error("cache overflowed");
  no_cache_a: assert property (!trig_cfg.cache_en |=> pend_reg == 2'h0) else $error("trigger cached while off");
  exp_after_pre_a: assert property (exp_go_reg |-> $past(st_reg) == ST_PRE && $past(pre_done)) else $error("exposure early");
  level_hold_a: assert property (st_reg == ST_IDLE && acq_en && trig_cfg.mode_on && level_mode && level_act
                                 |=> st_reg == ST_PRE) else $error("level not acquiring");
  strobe_inv_a: assert property (line1_out_reg == ($past(strobe_reg) ^ $past(strb_cfg.invert1)))
    else $error("line 1 level wrong");
  strobe_rise_a: assert property (sdly_done |=> strobe_reg ##1 sdur_go_reg == 1'b0) else $error("strobe not asserted");
  line2_drive_a: assert property (line2_oe_reg == $past(strb_cfg.line2_strobe)) else $error("line 2 drive wrong");
endmodule
`default_nettype wire

// >>> core/cts_debounce.sv
// cts_debounce: passes a new input level once it has stayed stable for the debounce time.
// assumes the input is synchronous to the clock and the tick marks each microsecond.
`timescale 1ns/1ps
`default_nettype none
module cts_debounce (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // input and setting
  input wire logic us_tick,
  input wire logic din,
  input wire logic [19:0] deb_us,
  // filtered level
  output logic dout_reg
);
  logic [19:0] cnt_reg;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      cnt_reg <= '0;
      dout_reg <= 1'b0;
    end
    else if (din != dout_reg)
    begin
      // any bounce back to the old level restarts the count
      // one tick more than the setting, as the first tick may come early
      if (cnt_reg > deb_us || deb_us == '0)
      begin
        dout_reg <= din;
        cnt_reg <= '0;
      end
      else if (us_tick)
        cnt_reg <= cnt_reg + 1'b1;
    end
    else
      cnt_reg <= '0;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  deb_pass_a: assert property ($changed(dout_reg) |-> $past(cnt_reg > deb_us || deb_us == '0))
    else $error("level passed early");
endmodule
`default_nettype wire

// >>> core/cts_pkg.sv
// cts_pkg: constants, enumerations and configuration carriers for the trigger and strobe block.
// assumes a single 100 MHz clock domain; all time settings are held in microseconds.
package cts_pkg;
  // clock and microsecond tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int US_W = 24;
  // burst frame count
  localparam logic [9:0] BURST_MIN = 10'h001;
  localparam logic [9:0] BURST_MAX = 10'h3ff;
  localparam logic [9:0] BURST_RST = 10'h001;
  // trigger cache
  localparam logic [1:0] CACHE_MAX = 2'h3;
  // limits in microseconds
  localparam logic [19:0] DEBOUNCE_MAX_US = 20'hf4240;
  localparam logic [13:0] STROBE_DELAY_MAX_US = 14'h2710;
  // idle level of the output lines, inversion off
  localparam logic LINE_RST = 1'b0;

  typedef enum logic [2:0] {ACT_RISE, ACT_FALL, ACT_ANY, ACT_HIGH, ACT_LOW} cts_act_t;

  typedef enum logic [3:0] {
    SRC_EXP_START, SRC_EXP_END, SRC_ACQ_START, SRC_ACQ_STOP, SRC_BURST_START, SRC_BURST_END,
    SRC_FRAME_WAIT, SRC_FRAME_START, SRC_FRAME_END, SRC_SOFT, SRC_HARD, SRC_COUNTER, SRC_TIMER
  } cts_src_t;
  localparam int SRC_N = 13;

  typedef struct packed {
    logic mode_on;
    logic cache_en;
    logic hw_line2;
    cts_act_t act;
    logic [US_W-1:0] delay_us;
    logic [19:0] debounce_us;
  } cts_trig_cfg_t;

  typedef struct packed {
    logic strobe_en;
    logic line2_strobe;
    logic invert1;
    logic invert2;
    cts_src_t src;
    logic [US_W-1:0] duration_us;
    logic [13:0] delay_us;
    logic [US_W-1:0] pre_delay_us;
  } cts_strb_cfg_t;
endpackage

// >>> core/cts_us_timer.sv
// cts_us_timer: one-shot microsecond timer, counted on a shared microsecond tick.
// assumes the tick is a one-cycle pulse; the first microsecond may be partial.
`timescale 1ns/1ps
`default_nettype none
module cts_us_timer #(
  parameter int W = cts_pkg::US_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // control
  input wire logic us_tick,
  input wire logic start,
  input wire logic [W-1:0] count_us,
  // status
  output logic busy_reg,
  output logic done_reg
);
  logic [W-1:0] rem_reg;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      rem_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (start)
      begin
        rem_reg <= count_us;
        busy_reg <= (count_us != '0);
        done_reg <= (count_us == '0);
      end
      else if (busy_reg && us_tick)
      begin
        rem_reg <= rem_reg - 1'b1;
        if (rem_reg == {{(W-1){1'b0}}, 1'b1})
        begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  zero_count_a: assert property (start && count_us == '0 |=> done_reg) else $error("zero count not done");
endmodule
`default_nettype wire

// >>> sim/camera_trigger_strobe_ctrl_tb.sv
// camera_trigger_strobe_ctrl_tb: self-checking bench of the trigger and strobe core.
// assumes the core at 100 MHz with small microsecond settings to keep the run short.
`timescale 1ns/1ps
`default_nettype none
module camera_trigger_strobe_ctrl_tb;
  logic clock;
  logic rstn;
  logic sw_trig;
  logic cnt_trig;
  logic line_trig_sw;
  logic acq_en;
  logic line2_in;
  logic burst_wr;
  logic [9:0] burst_val;
  logic [cts_pkg::US_W-1:0] exposure_us;
  cts_pkg::cts_trig_cfg_t trig_cfg;
  cts_pkg::cts_strb_cfg_t strb_cfg;
  wire logic line0_in;
  wire logic frame_done;
  logic line2_out_reg;
  logic line2_oe_reg;
  logic line1_out_reg;
  logic [9:0] burst_reg;
  logic multi_frame_reg;
  logic exposing_reg;
  logic trig_wait_reg;
  logic [1:0] pend_reg;
  int n_errors = 0;
  int cmp_count = 0;
  int mq[$];
  integer seed = 32'hf2e7d636;
  int nb;
  int d;
  int p;
  int a;
  int b;
  int k;
  int base = 0;

  cts_core cts_core_inst (.clock(clock), .rstn(rstn), .line0_in(line0_in), .sw_trig(sw_trig),
    .cnt_trig(cnt_trig), .line_trig_sw(line_trig_sw), .acq_en(acq_en), .frame_done(frame_done),
    .line2_in(line2_in), .line2_out_reg(line2_out_reg), .line2_oe_reg(line2_oe_reg),
    .trig_cfg(trig_cfg), .strb_cfg(strb_cfg), .exposure_us(exposure_us), .burst_wr(burst_wr),
    .burst_val(burst_val), .line1_out_reg(line1_out_reg), .burst_reg(burst_reg),
    .multi_frame_reg(multi_frame_reg), .exposing_reg(exposing_reg),
    .trig_wait_reg(trig_wait_reg), .pend_reg(pend_reg));

  cts_ext_model cts_ext_model_inst (.clock(clock), .exposing(exposing_reg), .line0(line0_in),
    .frame_done(frame_done));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic in_range(input string what, input int v, input int lo, input int hi);
    check(what, 32'(v >= lo && v <= hi), 32'h1);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic int rnd(input int n);
    return int'({1'b0, $random(seed)} % n);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // reference: a trigger is taken when idle, or cached while fewer than three wait
  task automatic model_trig(input logic cache);
    if (mq.size() == 0 || (cache && mq.size() < 4))
      mq.push_back(nb);
  endtask

  task automatic setb(input int v, input int exp);
    burst_wr <= 1'b1;
    burst_val <= 10'(v);
    cyc(1);
    burst_wr <= 1'b0;
    cyc(2);
    check("burst count", burst_reg, exp);
    check("multi frame", multi_frame_reg, exp > 1);
  endtask

  task automatic strike(input int which);
    case (which)
      0: sw_trig <= 1'b1;
      1: cnt_trig <= 1'b1;
      default: line_trig_sw <= 1'b1;
    endcase
    cyc(1);
    sw_trig <= 1'b0;
    cnt_trig <= 1'b0;
    line_trig_sw <= 1'b0;
    cyc(1);
  endtask

  // cycles until exposure (sel 0) or opto output (sel 1) reaches a level
  task automatic lead(input int sel, input logic lvl, output int n);
    n = 0;
    while ((sel == 0 ? exposing_reg : line1_out_reg) !== lvl && n < 3000)
    begin
      cyc(1);
      n++;
    end
  endtask

  // idle long enough that no frame can still be on its way, then compare frame totals
  task automatic settle();
    int q;
    int s;
    q = 0;
    s = 0;
    for (int i = 0; i < 40000 && q < 700; i++)
    begin
      cyc(1);
      q = (trig_wait_reg === 1'b1 && pend_reg === 2'h0 && cts_ext_model_inst.rd == 0) ? q + 1 : 0;
    end
    foreach (mq[i])
      s += mq[i];
    check("idle reached", 32'(q >= 700), 32'h1);
    check("exposures", 32'(cts_ext_model_inst.n_exp - base), 32'(s));
    base = cts_ext_model_inst.n_exp;
    mq.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    sw_trig = 1'b0;
    cnt_trig = 1'b0;
    line_trig_sw = 1'b0;
    acq_en = 1'b1;
    line2_in = 1'b0;
    burst_wr = 1'b0;
    burst_val = 10'h000;
    exposure_us = 24'h000002;
    trig_cfg = '0;
    strb_cfg = '0;
    trig_cfg.mode_on = 1'b1;
    cyc(12);
    rstn <= 1'b1;
    cyc(1);
    check("opto idle", line1_out_reg, 1'b0);
    check("line2 enable", line2_oe_reg, 1'b0);
    check("burst reset", burst_reg, 10'h001);
    check("pending reset", pend_reg, 2'h0);
    nb = 2 + rnd(3);
    setb(0, 1);
    setb(1023, 1023);
    setb(nb, nb);
    // burst with trigger delay and pre-delay; extra triggers dropped without cache
    d = 1 + rnd(4);
    p = rnd(3);
    trig_cfg.delay_us <= 24'(d);
    strb_cfg.pre_delay_us <= 24'(p);
    strb_cfg.strobe_en <= 1'b1;
    cyc(300);
    strike(0);
    model_trig(1'b0);
    lead(1, 1'b1, a);
    lead(0, 1'b1, b);
    in_range("strobe lead", b, p * 100 - 100, p * 100 + 20);
    in_range("trigger lead", a + b, (d + p) * 100 - 200, (d + p) * 100 + 30);
    strike(0);
    model_trig(1'b0);
    strike(1);
    model_trig(1'b0);
    check("pending no cache", pend_reg, 2'h0);
    settle();
    // cache with a slow readout: three kept, the rest dropped
    trig_cfg.cache_en <= 1'b1;
    cts_ext_model_inst.read_cyc = 300;
    strike(0);
    model_trig(1'b1);
    for (k = 0; k < 5; k++)
    begin
      strike(k % 2);
      model_trig(1'b1);
    end
    check("pending full", pend_reg, 2'h3);
    settle();
    check("early exposure", 32'(cts_ext_model_inst.n_early), 32'h0);
    cts_ext_model_inst.read_cyc = 40;
    trig_cfg.cache_en <= 1'b0;
    // software line trigger on the timer source, mirrored on line 2
    d = 1 + rnd(5);
    strb_cfg.src <= cts_pkg::SRC_TIMER;
    strb_cfg.delay_us <= 14'(d);
    strb_cfg.duration_us <= 24'h000003;
    strb_cfg.line2_strobe <= 1'b1;
    cyc(2);
    strike(2);
    lead(1, 1'b1, a);
    in_range("strobe delay", a, d * 100 - 110, d * 100 + 10);
    check("line2 driven", line2_oe_reg, 1'b1);
    check("line2 level", line2_out_reg, 1'b1);
    lead(1, 1'b0, b);
    in_range("strobe width", b, 200, 310);
    strb_cfg.strobe_en <= 1'b0;
    cyc(2);
    strike(2);
    lead(1, 1'b1, a);
    check("strobe disabled", 32'(a), 32'd3000);
    // zero duration follows exposure time, inverted output
    strb_cfg.strobe_en <= 1'b1;
    strb_cfg.invert1 <= 1'b1;
    strb_cfg.src <= cts_pkg::SRC_EXP_START;
    strb_cfg.duration_us <= '0;
    strb_cfg.pre_delay_us <= '0;
    strb_cfg.delay_us <= '0;
    trig_cfg.delay_us <= '0;
    exposure_us <= 24'h000003;
    cyc(2);
    check("inverted idle", line1_out_reg, 1'b1);
    strike(0);
    model_trig(1'b0);
    lead(1, 1'b0, a);
    lead(1, 1'b1, b);
    in_range("exposure width", b, 200, 310);
    settle();
    strb_cfg.invert1 <= 1'b0;
    // hardware line: short pulse filtered, then each edge activation
    trig_cfg.debounce_us <= 20'h00005;
    setb(1, 1);
    nb = 1;
    cts_ext_model_inst.drive(1'b1, 200);
    cts_ext_model_inst.drive(1'b0, 1500);
    settle();
    for (k = 0; k < 3; k++)
    begin
      trig_cfg.act <= cts_pkg::cts_act_t'(k);
      cts_ext_model_inst.drive(1'b1, 3000);
      cts_ext_model_inst.drive(1'b0, 3000);
      repeat ((k == 2) ? 2 : 1) mq.push_back(1);
      settle();
    end
    // level activation keeps acquiring only while the level is held
    trig_cfg.act <= cts_pkg::ACT_HIGH;
    cts_ext_model_inst.drive(1'b1, 4000);
    cts_ext_model_inst.drive(1'b0, 1000);
    a = cts_ext_model_inst.n_exp - base;
    in_range("level frames", a, 2, 40);
    cyc(2000);
    check("level stop", 32'(cts_ext_model_inst.n_exp - base), 32'(a));
    base = cts_ext_model_inst.n_exp;
    // trigger mode off: frames without any trigger
    trig_cfg.act <= cts_pkg::ACT_RISE;
    trig_cfg.mode_on <= 1'b0;
    cyc(3000);
    in_range("free run", cts_ext_model_inst.n_exp - base, 1, 100);
    // software and counter sources, line 2 inverted; strobe starts on the third edge
    strb_cfg.invert2 <= 1'b1;
    strb_cfg.duration_us <= 24'h000001;
    for (k = 0; k < 2; k++)
    begin
      strb_cfg.src <= k ? cts_pkg::SRC_COUNTER : cts_pkg::SRC_SOFT;
      cyc(400);
      strike(k);
      lead(1, 1'b1, a);
      check("source strobe", 32'(a), 32'd3);
      check("line2 inverted", line2_out_reg, 1'b0);
    end
    results();
  end

  // cut a hang short well beyond the expected run length
  initial
  begin
    #1000000;
    n_errors++;
    results();
  end
endmodule
`default_nettype wire

// >>> sim/cts_ext_model.sv
// cts_ext_model: outside world of the trigger and strobe block: trigger line and frame readout.
// assumes one clock; readout time is a run-time knob so the bench can stall the camera.
`timescale 1ns/1ps
`default_nettype none
module cts_ext_model #(
  parameter int READ_CYC = 40
) (
  // clock
  input wire logic clock,
  // from the block
  input wire logic exposing,
  // to the block
  output logic line0,
  output logic frame_done
);
  int read_cyc = READ_CYC;
  int n_exp = 0;
  int n_early = 0;
  int rd = 0;
  logic exp_q = 1'b0;

  initial
  begin
    line0 = 1'b0;
    frame_done = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // readout finishes a set time after exposure ends; a new exposure while
  // readout is still pending means the previous frame was not yet created
  always @(posedge clock)
  begin
    exp_q <= exposing;
    if (exposing === 1'b1 && exp_q === 1'b0)
    begin
      n_exp <= n_exp + 1;
      if (rd > 0)
        n_early <= n_early + 1;
    end
    if (exposing === 1'b0 && exp_q === 1'b1)
      rd <= read_cyc;
    else if (rd > 0)
      rd <= rd - 1;
    frame_done <= (rd == 1);
  end

  // trigger line level held for a number of cycles
  task automatic drive(input logic lvl, input int cyc);
    line0 <= lvl;
    repeat (cyc) @(posedge clock);
  endtask
endmodule
`default_nettype wire
